// ===== rtl/trig_holdoff_pkg.sv
// Constants for the external trigger holdoff and trigger output block
package trig_holdoff_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned CLK_PERIOD_NS = 1000 / CLK_MHZ;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] HOLDOFF_OFS = 8'h04;
  localparam logic [7:0] LEVEL_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;
  localparam logic [7:0] COUNT_OFS = 8'h10;

  // Control fields
  localparam int CTRL_EXT_BIT = 0;
  localparam int CTRL_NEG_BIT = 1;
  localparam int CTRL_FINE_BIT = 2;
  localparam int CTRL_STEP_LSB = 8;
  localparam int CTRL_STEP_W = 5;

  // Holdoff coarse steps: 1us .. 1s, 1-2-5 per decade, 19 entries
  localparam int unsigned HOLDOFF_STEPS = 19;
  localparam logic [4:0] HOLDOFF_STEP_MAX = 5'h12;
  localparam int unsigned HOLDOFF_MIN_US = 1;
  // Fine holdoff granularity
  localparam int unsigned FINE_STEP_NS = 200;
  localparam int unsigned FINE_STEP_CYC = FINE_STEP_NS / CLK_PERIOD_NS;
  localparam int FINE_W = 23;

  // Level setpoint in mV, signed, -1000 .. 1000
  localparam int LEVEL_W = 12;
  localparam logic signed [11:0] LEVEL_MAX = 12'sh3e8;
  localparam logic signed [11:0] LEVEL_MIN = -12'sh3e8;
  localparam logic signed [11:0] LEVEL_RST = 12'sh064;
  localparam logic [11:0] LEVEL_COARSE_MV = 12'h00a;
  localparam int LEVEL_ROUND_BIT = 16;

  // Output timing
  localparam int unsigned TRIG_OUT_NS = 500;
  localparam int unsigned TRIG_OUT_CYC = TRIG_OUT_NS / CLK_PERIOD_NS;
  localparam int unsigned IN_DELAY_NS = 4;
  localparam int unsigned STEP_LEAD_NS = 40;
  localparam int unsigned STEP_LEAD_CYC = STEP_LEAD_NS / CLK_PERIOD_NS;
  localparam int unsigned TDH_LEAD_NS = 42;
  localparam int unsigned TDH_LEAD_CYC = TDH_LEAD_NS / CLK_PERIOD_NS;

  localparam int CNT_W = 27;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
endpackage : trig_holdoff_pkg

// ===== rtl/holdoff_timer.sv
// Holdoff down-counter: blocks triggers for a loaded number of cycles
module holdoff_timer
  import trig_holdoff_pkg::*;
(
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Sync reset
  input wire logic start_i, // Load and start
  input wire logic [CNT_W-1:0] load_i, // Cycles to block
  output logic busy_o // Holdoff active
);
  logic [CNT_W-1:0] cnt_reg;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cnt_reg <= '0;
    else if (start_i)
      cnt_reg <= load_i;
    else if (cnt_reg != '0)
      cnt_reg <= cnt_reg - CNT_W'(1);
  end

  assign busy_o = (cnt_reg != '0);
endmodule : holdoff_timer

// ===== rtl/ext_trigger_holdoff_pulse_out.sv
// External trigger qualifier, holdoff, and trigger/pulse output timing
//
// Our own choices: the Wishbone register port and the address map.
module ext_trigger_holdoff_pulse_out
  import trig_holdoff_pkg::*;
(
  input wire logic clk_i, // 100 MHz clock
  input wire logic rst_i, // Sync reset, active high
  input wire logic trig_in_i, // Comparator output, async
  input wire logic int_period_i, // Internal period tick
  input wire logic [31:0] adr_i, // Wishbone address
  input wire logic [31:0] dat_i, // Wishbone write data
  output logic [31:0] dat_o, // Wishbone read data
  input wire logic [3:0] sel_i, // Wishbone byte selects
  input wire logic we_i, // Wishbone write enable
  input wire logic cyc_i, // Wishbone cycle
  input wire logic stb_i, // Wishbone strobe
  output logic ack_o, // Wishbone ack
  output logic [LEVEL_W-1:0] level_setpoint_o, // Threshold in mV
  output logic trig_out_o, // Trigger output pulse
  output logic step_recovery_outputs_o, // Step recovery fire
  output logic tunnel_diode_head_output_o // Tunnel diode head fire
);
  logic [31:0] ctrl_reg;
  logic [FINE_W-1:0] fine_reg;
  logic signed [LEVEL_W-1:0] level_reg;
  logic [31:0] count_reg;
  logic sync1_reg, sync2_reg, prev_reg;
  logic [8:0] pulse_cnt_reg;
  logic [TDH_LEAD_CYC:0] lead_reg;
  logic ack_reg;
  logic holdoff_busy;
  logic edge_seen, accept;
  logic [CNT_W-1:0] holdoff_cyc;
  logic [4:0] step_idx;

  // Coarse holdoff table in microseconds
  function automatic logic [CNT_W-1:0] coarse_us(input logic [4:0] idx);
    logic [CNT_W-1:0] base;
    logic [CNT_W-1:0] dec;
    base = '0;
    dec = CNT_W'(HOLDOFF_MIN_US);
    for (int d = 0; d < 7; d++)
    begin
      if (idx / 5'h03 == 5'(d))
      begin
        case (idx % 5'h03)
          5'h00: base = dec;
          5'h01: base = CNT_W'(dec * 2);
          default: base = CNT_W'(dec * 5);
        endcase
      end
      dec = CNT_W'(dec * 10);
    end
    return base;
  endfunction : coarse_us

  assign step_idx = (ctrl_reg[CTRL_STEP_LSB +: CTRL_STEP_W] > HOLDOFF_STEP_MAX) ?
    HOLDOFF_STEP_MAX : ctrl_reg[CTRL_STEP_LSB +: CTRL_STEP_W];

  // Coarse value, or fine value in 200 ns units
  always_comb
  begin
    if (ctrl_reg[CTRL_FINE_BIT])
      holdoff_cyc = CNT_W'(fine_reg * FINE_STEP_CYC);
    else
      holdoff_cyc = CNT_W'(coarse_us(step_idx) * (1000 / CLK_PERIOD_NS));
  end

  // Two-stage synchroniser, then edge history
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= trig_in_i;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // Edge select
  assign edge_seen = ctrl_reg[CTRL_NEG_BIT] ? (prev_reg & ~sync2_reg) : (~prev_reg & sync2_reg);

  always_comb
  begin
    if (ctrl_reg[CTRL_EXT_BIT])
      accept = edge_seen & ~holdoff_busy;
    else
      accept = int_period_i;
  end

  holdoff_timer u_holdoff (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(accept & ctrl_reg[CTRL_EXT_BIT]),
    .load_i(holdoff_cyc),
    .busy_o(holdoff_busy)
  );

  // Trigger output pulse; set on the accept edge, fixed width
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pulse_cnt_reg <= '0;
    else if (accept)
      pulse_cnt_reg <= 9'(TRIG_OUT_CYC);
    else if (pulse_cnt_reg != '0)
      pulse_cnt_reg <= pulse_cnt_reg - 9'h001;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      trig_out_o <= 1'b0;
    else
      trig_out_o <= accept | (pulse_cnt_reg > 9'h001);
  end

  // Lead delay line from trigger output rise to main outputs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      lead_reg <= '0;
    else
      lead_reg <= {lead_reg[TDH_LEAD_CYC-1:0], accept};
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      step_recovery_outputs_o <= 1'b0;
      tunnel_diode_head_output_o <= 1'b0;
    end
    else
    begin
      step_recovery_outputs_o <= lead_reg[STEP_LEAD_CYC-1];
      tunnel_diode_head_output_o <= lead_reg[TDH_LEAD_CYC];
    end
  end

  // Period counter
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      count_reg <= '0;
    else if (accept)
      count_reg <= count_reg + 32'h0000_0001;
  end

  // Wishbone slave, one wait state; writes land on the ack edge
  logic wr_hit;
  assign wr_hit = cyc_i & stb_i & we_i & ack_reg;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_reg <= 1'b0;
    else
      ack_reg <= cyc_i & stb_i & ~ack_reg;
  end
  assign ack_o = ack_reg;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl_reg <= CTRL_RST;
    else if (wr_hit && adr_i[7:0] == CTRL_OFS)
    begin
      for (int b = 0; b < 4; b++)
        if (sel_i[b])
          ctrl_reg[8*b +: 8] <= dat_i[8*b +: 8];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      fine_reg <= FINE_W'(1000 / FINE_STEP_NS);
    else if (wr_hit && adr_i[7:0] == HOLDOFF_OFS && sel_i != 4'h0)
      fine_reg <= (dat_i[FINE_W-1:0] == '0) ? FINE_W'(1) : dat_i[FINE_W-1:0];
  end

  // Level: 1 mV units; bit 16 set requests truncation toward zero to a 10 mV step
  logic signed [LEVEL_W-1:0] level_wr;
  always_comb
  begin
    level_wr = dat_i[LEVEL_W-1:0];
    if (dat_i[LEVEL_ROUND_BIT])
      level_wr = LEVEL_W'(($signed(level_wr) / $signed(LEVEL_COARSE_MV)) * $signed(LEVEL_COARSE_MV));
    if (level_wr > LEVEL_MAX)
      level_wr = LEVEL_MAX;
    else if (level_wr < LEVEL_MIN)
      level_wr = LEVEL_MIN;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      level_reg <= LEVEL_RST;
    else if (wr_hit && adr_i[7:0] == LEVEL_OFS && sel_i[1:0] == 2'h3)
      level_reg <= level_wr;
  end
  assign level_setpoint_o = level_reg;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_o <= '0;
    else
    begin
      case (adr_i[7:0])
        CTRL_OFS: dat_o <= ctrl_reg;
        HOLDOFF_OFS: dat_o <= 32'(fine_reg);
        LEVEL_OFS: dat_o <= 32'($unsigned(level_reg));
        STATUS_OFS: dat_o <= {29'h0, holdoff_busy, trig_out_o, sync2_reg};
        COUNT_OFS: dat_o <= count_reg;
        default: dat_o <= '0;
      endcase
    end
  end
endmodule : ext_trigger_holdoff_pulse_out

// ===== verif/ext_trig_sva.sv
// Timing and handshake checks at the trigger block ports
module ext_trig_chk
  import trig_holdoff_pkg::*;
(
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic cyc_i, // Cycle
  input wire logic stb_i, // Strobe
  input wire logic ack_o, // Ack
  input wire logic [LEVEL_W-1:0] level_setpoint_o, // Level
  input wire logic trig_out_o, // Trigger pulse
  input wire logic step_recovery_outputs_o, // Main pulse
  input wire logic tunnel_diode_head_output_o // Head pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic [7:0] hi_cnt;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      hi_cnt <= 8'h00;
    else
      hi_cnt <= trig_out_o ? hi_cnt + 8'h01 : 8'h00;
  end
  sequence s_step;
    ##4 step_recovery_outputs_o ##1 !step_recovery_outputs_o;
  endsequence
  sequence s_tdh;
    ##5 tunnel_diode_head_output_o ##1 !tunnel_diode_head_output_o;
  endsequence
  a_out_width: assert property ($fell(trig_out_o) |-> hi_cnt == TRIG_OUT_CYC)
    else $error("width");
  a_out_max: assert property (hi_cnt <= TRIG_OUT_CYC)
    else $error("too long");
  a_step_lead: assert property ($rose(trig_out_o) |-> s_step)
    else $error("step lead");
  a_tdh_lead: assert property ($rose(trig_out_o) |-> s_tdh)
    else $error("head lead");
  a_step_cause: assert property ($rose(step_recovery_outputs_o) |-> $past(trig_out_o, 4) && !$past(trig_out_o, 5))
    else $error("step cause");
  a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("long ack");
  a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("stray ack");
  a_level_reset: assert property ($fell(rst_i) |-> level_setpoint_o == LEVEL_RST)
    else $error("level reset");
endmodule : ext_trig_chk

bind ext_trigger_holdoff_pulse_out ext_trig_chk chk_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .ack_o(ack_o), .level_setpoint_o(level_setpoint_o), .trig_out_o(trig_out_o),
  .step_recovery_outputs_o(step_recovery_outputs_o), .tunnel_diode_head_output_o(tunnel_diode_head_output_o));

// ===== verif/trig_source.sv
// External trigger source model driving the comparator input
module trig_source
(
  input wire logic clk_i, // Clock
  output logic trig_o // Trigger level
);
  timeunit 1ns;
  timeprecision 1ps;
  initial trig_o = 1'b0;
  task hold(input logic v, input int n);
    @(posedge clk_i);
    trig_o <= v;
    repeat (n) @(posedge clk_i);
  endtask : hold
endmodule : trig_source

// ===== verif/tb.sv
// Bench for trigger holdoff and trigger output
module tb
  import trig_holdoff_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [31:0] adr = 32'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack, trig_in, trig_out, step_out, tdh, prev;
  logic tick = 1'b0;
  logic [LEVEL_W-1:0] lvl;
  int failures = 0;
  int check_count = 0;
  int pulses = 0;
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    if (trig_out === 1'b1 && prev !== 1'b1)
      pulses++;
    prev <= trig_out;
  end
  ext_trigger_holdoff_pulse_out dut_u (.clk_i(clk_i), .rst_i(rst_i), .trig_in_i(trig_in), .int_period_i(tick),
    .adr_i(adr), .dat_i(wdat), .dat_o(rdat), .sel_i(4'hf), .we_i(we), .cyc_i(cyc), .stb_i(cyc), .ack_o(ack),
    .level_setpoint_o(lvl), .trig_out_o(trig_out), .step_recovery_outputs_o(step_out),
    .tunnel_diode_head_output_o(tdh));
  trig_source src_u (.clk_i(clk_i), .trig_o(trig_in));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= {24'h0, a};
    wdat <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    if (n >= 20)
    begin
      failures++;
      $display("CHECK FAILED %0t no ack", $time);
    end
  endtask : wb
  task lvl_case(input logic [31:0] d, input logic [11:0] e);
    wb(1'b1, LEVEL_OFS, d);
    wb(1'b0, LEVEL_OFS, 32'h0);
    chk({20'h0, q[11:0]}, {20'h0, e});
    chk({20'h0, lvl}, {20'h0, e});
  endtask : lvl_case
  task results;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results
  initial
  begin
    #50000;
    failures++;
    $display("CHECK FAILED %0t timeout", $time);
    results();
  end
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    chk({20'h0, lvl}, 32'h064);
    wb(1'b0, 8'h20, 32'h0);
    chk(q, 32'h0);
    lvl_case(32'h0000_fffb, 12'hffb);
    lvl_case(32'h0001_0017, 12'h014);
    lvl_case(32'h0000_07d0, 12'h3e8);
    $display("test level done");
    wb(1'b1, CTRL_OFS, 32'h1);
    src_u.hold(1'b1, 6);
    chk({31'h0, trig_out}, 32'h1);
    wb(1'b0, STATUS_OFS, 32'h0);
    chk(q, 32'h7);
    src_u.hold(1'b0, 60);
    src_u.hold(1'b1, 20);
    src_u.hold(1'b0, 20);
    src_u.hold(1'b1, 10);
    chk(pulses, 2);
    src_u.hold(1'b0, 120);
    wb(1'b0, COUNT_OFS, 32'h0);
    chk(q, 32'h2);
    $display("test coarse holdoff done");
    wb(1'b1, CTRL_OFS, 32'h7);
    wb(1'b1, HOLDOFF_OFS, 32'h1);
    src_u.hold(1'b1, 30);
    chk(pulses, 2);
    src_u.hold(1'b0, 40);
    src_u.hold(1'b1, 20);
    src_u.hold(1'b0, 40);
    chk(pulses, 4);
    $display("test fine holdoff done");
    wb(1'b1, CTRL_OFS, 32'h0);
    src_u.hold(1'b0, 60);
    tick <= 1'b1;
    @(posedge clk_i);
    tick <= 1'b0;
    src_u.hold(1'b0, 60);
    chk(pulses, 5);
    wb(1'b0, COUNT_OFS, 32'h0);
    chk(q, 32'h5);
    $display("test internal period done");
    results();
  end
endmodule : tb
